/* File: logic/eeprom_defs.svh */
`ifndef EEPROM_DEFS_SVH
`define EEPROM_DEFS_SVH

// ==========================================
// Timing
`define CLK_MHZ 40
`define EE_SK_HALF_NS 500
`define EE_SK_HALF_CYC ((`EE_SK_HALF_NS * `CLK_MHZ + 999) / 1000)
`define EE_TIMEOUT_MS 10
`define EE_TIMEOUT_CYC (`EE_TIMEOUT_MS * `CLK_MHZ * 1000)

// ==========================================
// Register offsets
`define REG_CMD_OFF 8'hB0
`define REG_DATA_OFF 8'hB4
`define REG_STS_OFF 8'hB8
`define REG_IEN_OFF 8'hBC
`define REG_ICLR_OFF 8'hC0

// ==========================================
// Fields and reset values
`define CMD_BUSY_BIT 31
`define CMD_OP_HI 30
`define CMD_OP_LO 28
`define CMD_ADDR_HI 7
`define CMD_BUSY_RST 1'b1
`define CMD_OP_RST 3'h0
`define STS_DONE_BIT 0
`define STS_TMO_BIT 1
`define STS_LOAD_BIT 2
`define STS_W 3
`define LOAD_LAST 3'h6
`define SIG_RST 8'hA5

// ==========================================
// Serial frame encoding
`define MW_START 1'b1
`define MW_OP_READ 2'h2
`define MW_OP_WRITE 2'h1
`define MW_OP_ERASE 2'h3
`define MW_OP_EXT 2'h0
`define MW_EXT_EWDS 8'h00
`define MW_EXT_WRAL 8'h40
`define MW_EXT_ERAL 8'h80
`define MW_EXT_EWEN 8'hC0
`define MW_HDR_BITS 5'h0B
`define MW_FULL_BITS 5'h13

`endif

/* File: logic/eeprom_pkg.sv */
package eeprom_pkg;

    typedef enum logic [2:0] {
        OP_READ = 3'h0,
        OP_EWDS = 3'h1,
        OP_EWEN = 3'h2,
        OP_WRITE = 3'h3,
        OP_WRAL = 3'h4,
        OP_ERASE = 3'h5,
        OP_ERAL = 3'h6,
        OP_RELOAD = 3'h7
    } op_t;

    typedef enum logic [2:0] {
        CTL_IDLE = 3'b001,
        CTL_RUN = 3'b010,
        CTL_LOAD = 3'b100
    } ctl_state_t;

    typedef enum logic [3:0] {
        ENG_IDLE = 4'b0001,
        ENG_SHIFT = 4'b0010,
        ENG_GAP = 4'b0100,
        ENG_WAIT = 4'b1000
    } eng_state_t;

endpackage

/* File: logic/eeprom_serial_engine.sv */
`timescale 1ns/1ps
`include "eeprom_defs.svh"
module eeprom_serial_engine
    import eeprom_pkg::*;
#(
    parameter int HALF_CYC = `EE_SK_HALF_CYC,
    parameter int TIMEOUT_CYC = `EE_TIMEOUT_CYC
) (
    input wire logic clk,
    input wire logic rst,
    input wire logic start,
    input wire logic [18:0] tx_word,
    input wire logic [4:0] tx_bits,
    input wire logic wait_rdy,
    input wire logic di,
    output logic cs,
    output logic sk,
    output logic dout,
    output logic done,
    output logic timed_out,
    output logic [7:0] rx_byte
);
    localparam int DW = $clog2(HALF_CYC + 1);
    localparam int TW = $clog2(TIMEOUT_CYC + 1);

    eng_state_t state_ff;
    logic [DW-1:0] div_ff;
    logic [TW-1:0] to_ff;
    logic [4:0] bit_ff;
    logic [18:0] sh_ff;
    logic wait_ff;
    logic tick;
    logic to_hit;

    assign tick = div_ff == DW'(HALF_CYC - 1);
    assign to_hit = to_ff == TW'(TIMEOUT_CYC - 1);

    // ==========================================
    // Divider: one enable per half serial clock
    always_ff @(posedge clk) begin
        if (rst || state_ff == ENG_IDLE || tick) begin
            div_ff <= '0;
        end else begin
            div_ff <= div_ff + DW'(1);
        end
    end

    // ==========================================
    // Frame sequencer
    always_ff @(posedge clk) begin
        done <= 1'b0;
        timed_out <= 1'b0;
        if (rst) begin
            state_ff <= ENG_IDLE;
            cs <= 1'b0;
            sk <= 1'b0;
            dout <= 1'b0;
            bit_ff <= 5'h00;
            sh_ff <= 19'h0_0000;
            wait_ff <= 1'b0;
            to_ff <= '0;
            rx_byte <= 8'h00;
        end else begin
            case (state_ff)
                ENG_IDLE: begin
                    if (start) begin
                        cs <= 1'b1;
                        sh_ff <= tx_word;
                        bit_ff <= tx_bits;
                        wait_ff <= wait_rdy;
                        dout <= tx_word[18];
                        state_ff <= ENG_SHIFT;
                    end
                end
                ENG_SHIFT: begin
                    if (tick && !sk) begin
                        sk <= 1'b1;
                    end else if (tick) begin
                        // Sample late in the high phase: pin sync delay
                        sk <= 1'b0;
                        rx_byte <= {rx_byte[6:0], di};
                        sh_ff <= {sh_ff[17:0], 1'b0};
                        dout <= sh_ff[17];
                        bit_ff <= bit_ff - 5'h01;
                        if (bit_ff == 5'h01) begin
                            cs <= 1'b0;
                            dout <= 1'b0;
                            state_ff <= ENG_GAP;
                        end
                    end
                end
                ENG_GAP: begin
                    if (tick && wait_ff) begin
                        cs <= 1'b1;
                        to_ff <= '0;
                        state_ff <= ENG_WAIT;
                    end else if (tick) begin
                        done <= 1'b1;
                        state_ff <= ENG_IDLE;
                    end
                end
                ENG_WAIT: begin
                    // Missing part never raises ready
                    if (di || to_hit) begin
                        cs <= 1'b0;
                        done <= 1'b1;
                        timed_out <= !di;
                        state_ff <= ENG_IDLE;
                    end else begin
                        to_ff <= to_ff + TW'(1);
                    end
                end
                default: state_ff <= ENG_IDLE;
            endcase
        end
    end
endmodule // eeprom_serial_engine

/* File: logic/eeprom_command_control.sv */
`timescale 1ns/1ps
`include "eeprom_defs.svh"
module eeprom_command_control
    import eeprom_pkg::*;
#(
    parameter int TIMEOUT_CYC = `EE_TIMEOUT_CYC,
    parameter int HALF_CYC = `EE_SK_HALF_CYC,
    parameter logic [7:0] SIGNATURE = `SIG_RST
) (
    input wire logic CLOCK,
    input wire logic RST,
    input wire logic [7:0] ADDR,
    input wire logic [31:0] WDATA,
    input wire logic WR,
    input wire logic RD,
    output logic [31:0] RDATA,
    output logic IRQ,
    output logic EE_CS,
    output logic EE_CLK,
    output logic EE_DO,
    input wire logic EE_DI,
    output logic [47:0] MAC_ADDR,
    output logic MAC_VALID
);

    // ==========================================
    // State
    ctl_state_t state_ff;
    op_t op_ff;
    logic busy_ff;
    logic go_ff;
    logic [7:0] addr_ff;
    logic [7:0] data_ff;
    logic [2:0] idx_ff;
    logic [`STS_W-1:0] sts_ff;
    logic [`STS_W-1:0] ien_ff;
    logic irq_ff;
    logic [31:0] rdata_ff;
    logic [7:0] mac_ff [0:5];
    logic mac_valid_ff;
    logic di_s1_ff;
    logic di_s2_ff;
    logic di_s3_ff;
    logic di_ff;

    // ==========================================
    // Register decode
    logic sel_cmd;
    logic sel_data;
    logic sel_sts;
    logic sel_ien;
    logic sel_clr;
    logic wr_cmd;
    logic start_cmd;
    logic wr_data;
    logic [2:0] start_op;
    logic [31:0] rd_mux;

    assign sel_cmd = ADDR == `REG_CMD_OFF;
    assign sel_data = ADDR == `REG_DATA_OFF;
    assign sel_sts = ADDR == `REG_STS_OFF;
    assign sel_ien = ADDR == `REG_IEN_OFF;
    assign sel_clr = ADDR == `REG_ICLR_OFF;
    assign wr_cmd = WR && sel_cmd;
    assign start_cmd = wr_cmd && WDATA[`CMD_BUSY_BIT] && !busy_ff;
    // Data is frozen during an operation
    assign wr_data = WR && sel_data && !busy_ff;
    assign start_op = WDATA[`CMD_OP_HI:`CMD_OP_LO];

    assign rd_mux = sel_cmd ? {busy_ff, op_ff, 20'h0_0000, addr_ff} :
                    sel_data ? {24'h00_0000, data_ff} :
                    sel_sts ? {29'h0000_0000, sts_ff} :
                    sel_ien ? {29'h0000_0000, ien_ff} :
                    32'h0000_0000;

    // ==========================================
    // Serial engine link
    logic eng_done;
    logic eng_timeout;
    logic [7:0] eng_rx;
    logic [18:0] tx_word;
    logic [4:0] tx_bits;
    logic tx_wait;
    op_t eff_op;
    logic [7:0] eff_addr;

    assign eff_op = (state_ff == CTL_LOAD) ? OP_READ : op_ff;
    assign eff_addr = (state_ff == CTL_LOAD) ? {5'h00, idx_ff} : addr_ff;

    always_comb begin
        tx_word = {`MW_START, `MW_OP_EXT, `MW_EXT_EWDS, 8'h00};
        tx_bits = `MW_HDR_BITS;
        tx_wait = 1'b0;
        case (eff_op)
            OP_READ: begin
                tx_word = {`MW_START, `MW_OP_READ, eff_addr, 8'h00};
                tx_bits = `MW_FULL_BITS;
            end
            OP_EWDS: begin
                tx_word = {`MW_START, `MW_OP_EXT, `MW_EXT_EWDS, 8'h00};
            end
            OP_EWEN: begin
                tx_word = {`MW_START, `MW_OP_EXT, `MW_EXT_EWEN, 8'h00};
            end
            OP_WRITE: begin
                tx_word = {`MW_START, `MW_OP_WRITE, eff_addr, data_ff};
                tx_bits = `MW_FULL_BITS;
                tx_wait = 1'b1;
            end
            OP_WRAL: begin
                tx_word = {`MW_START, `MW_OP_EXT, `MW_EXT_WRAL, data_ff};
                tx_bits = `MW_FULL_BITS;
                tx_wait = 1'b1;
            end
            OP_ERASE: begin
                tx_word = {`MW_START, `MW_OP_ERASE, eff_addr, 8'h00};
                tx_wait = 1'b1;
            end
            OP_ERAL: begin
                tx_word = {`MW_START, `MW_OP_EXT, `MW_EXT_ERAL, 8'h00};
                tx_wait = 1'b1;
            end
            default: begin
                tx_word = {`MW_START, `MW_OP_EXT, `MW_EXT_EWDS, 8'h00};
            end
        endcase
    end

    eeprom_serial_engine #(
        .HALF_CYC(HALF_CYC),
        .TIMEOUT_CYC(TIMEOUT_CYC)
    ) u_engine (
        .clk(CLOCK),
        .rst(RST),
        .start(go_ff),
        .tx_word(tx_word),
        .tx_bits(tx_bits),
        .wait_rdy(tx_wait),
        .di(di_ff),
        .cs(EE_CS),
        .sk(EE_CLK),
        .dout(EE_DO),
        .done(eng_done),
        .timed_out(eng_timeout),
        .rx_byte(eng_rx)
    );

    // ==========================================
    // Data-in pin synchroniser
    always_ff @(posedge CLOCK) begin
        if (RST) begin
            di_s1_ff <= 1'b0;
            di_s2_ff <= 1'b0;
            di_s3_ff <= 1'b0;
            di_ff <= 1'b0;
        end else begin
            di_s1_ff <= EE_DI;
            di_s2_ff <= di_s1_ff;
            di_s3_ff <= di_s2_ff;
            if (di_s2_ff == di_s3_ff) begin
                di_ff <= di_s3_ff;
            end
        end
    end

    // ==========================================
    // Operation sequencing
    logic run_done;
    logic load_bad_sig;
    logic load_end;
    logic load_next;

    assign run_done = state_ff == CTL_RUN && eng_done;
    assign load_bad_sig = idx_ff == 3'h0 && eng_rx != SIGNATURE;
    // Failed load still ends the access
    assign load_end = state_ff == CTL_LOAD && eng_done &&
                      (load_bad_sig || idx_ff == `LOAD_LAST);
    assign load_next = state_ff == CTL_LOAD && eng_done && !load_end;

    always_ff @(posedge CLOCK) begin
        if (RST) begin
            state_ff <= CTL_LOAD;
            busy_ff <= `CMD_BUSY_RST;
            go_ff <= 1'b1;
            idx_ff <= 3'h0;
        end else begin
            go_ff <= start_cmd || load_next;
            if (start_cmd) begin
                busy_ff <= 1'b1;
                idx_ff <= 3'h0;
                state_ff <= (op_t'(start_op) == OP_RELOAD) ? CTL_LOAD
                                                           : CTL_RUN;
            end else if (run_done || load_end) begin
                // Timed-out writes end here too
                busy_ff <= 1'b0;
                state_ff <= CTL_IDLE;
            end else if (load_next) begin
                idx_ff <= idx_ff + 3'h1;
            end
        end
    end

    always_ff @(posedge CLOCK) begin
        if (RST) begin
            op_ff <= op_t'(`CMD_OP_RST);
            addr_ff <= 8'h00;
        end else if (start_cmd) begin
            op_ff <= op_t'(start_op);
            addr_ff <= WDATA[`CMD_ADDR_HI:0];
        end
    end

    always_ff @(posedge CLOCK) begin
        if (RST) begin
            data_ff <= 8'h00;
        end else if (run_done && op_ff == OP_READ) begin
            data_ff <= eng_rx;
        end else if (wr_data) begin
            data_ff <= WDATA[7:0];
        end
    end

    // ==========================================
    // Station address store
    genvar gi;
    generate
        for (gi = 0; gi < 6; gi++) begin : g_mac
            always_ff @(posedge CLOCK) begin
                if (RST) begin
                    mac_ff[gi] <= 8'h00;
                end else if (load_end || load_next) begin
                    if (idx_ff == 3'(gi + 1)) begin
                        mac_ff[gi] <= eng_rx;
                    end
                end
            end
        end
    endgenerate

    always_ff @(posedge CLOCK) begin
        if (RST) begin
            mac_valid_ff <= 1'b0;
        end else if (start_cmd && op_t'(start_op) == OP_RELOAD) begin
            mac_valid_ff <= 1'b0;
        end else if (load_end) begin
            mac_valid_ff <= !load_bad_sig;
        end
    end

    // ==========================================
    // Events and interrupt
    logic [`STS_W-1:0] sts_set;
    logic [`STS_W-1:0] sts_clr;
    logic [`STS_W-1:0] nxt_sts;

    assign sts_set = {load_end, run_done && eng_timeout, run_done};
    assign sts_clr = (WR && sel_clr) ? WDATA[`STS_W-1:0] : '0;
    // Set wins over a clear in the same cycle
    assign nxt_sts = (sts_ff & ~sts_clr) | sts_set;

    always_ff @(posedge CLOCK) begin
        if (RST) begin
            sts_ff <= '0;
            ien_ff <= '0;
            irq_ff <= 1'b0;
        end else begin
            sts_ff <= nxt_sts;
            irq_ff <= |(nxt_sts & ien_ff);
            if (WR && sel_ien) begin
                ien_ff <= WDATA[`STS_W-1:0];
            end
        end
    end

    always_ff @(posedge CLOCK) begin
        if (RST) begin
            rdata_ff <= 32'h0000_0000;
        end else begin
            rdata_ff <= RD ? rd_mux : 32'h0000_0000;
        end
    end

    assign RDATA = rdata_ff;
    assign IRQ = irq_ff;
    assign MAC_VALID = mac_valid_ff;
    assign MAC_ADDR = {mac_ff[5], mac_ff[4], mac_ff[3],
                       mac_ff[2], mac_ff[1], mac_ff[0]};

    // ==========================================
    // Checks
    default clocking cb @(posedge CLOCK); endclocking
    default disable iff (RST);

    sequence s_cmd_start;
        start_cmd;
    endsequence

    sequence s_read_end;
        state_ff == CTL_RUN && op_ff == OP_READ && eng_done;
    endsequence

    property p_start_runs;
        s_cmd_start |=> busy_ff && go_ff ##1 !go_ff;
    endproperty
    a_start_runs: assert property (p_start_runs)
        else $error("start did not launch one operation");

    property p_busy_holds;
        busy_ff && !eng_done |=> busy_ff;
    endproperty
    a_busy_holds: assert property (p_busy_holds)
        else $error("busy dropped before operation end");

    property p_read_valid;
        s_read_end |=> !busy_ff && data_ff == $past(eng_rx);
    endproperty
    a_read_valid: assert property (p_read_valid)
        else $error("busy cleared without read data");

    property p_write_waits;
        state_ff == CTL_RUN && op_ff == OP_WRITE && !eng_done |=> busy_ff;
    endproperty
    a_write_waits: assert property (p_write_waits)
        else $error("write busy ended before completion");

    property p_timeout_clears;
        eng_timeout |=> !busy_ff && sts_ff[`STS_TMO_BIT];
    endproperty
    a_timeout_clears: assert property (p_timeout_clears)
        else $error("time-out did not clear busy");

    property p_busy_after_reset;
        $past(RST) |-> busy_ff && state_ff == CTL_LOAD;
    endproperty
    a_busy_after_reset: assert property (p_busy_after_reset)
        else $error("busy not set after reset");

    property p_load_end;
        load_end |=> !busy_ff && sts_ff[`STS_LOAD_BIT];
    endproperty
    a_load_end: assert property (p_load_end)
        else $error("address load did not release busy");

    property p_op_field;
        s_cmd_start |=> op_ff == op_t'($past(start_op));
    endproperty
    a_op_field: assert property (p_op_field)
        else $error("operation field not taken");

    property p_cmd_read;
        RD && sel_cmd |=> RDATA[`CMD_BUSY_BIT] == $past(busy_ff);
    endproperty
    a_cmd_read: assert property (p_cmd_read)
        else $error("command word read wrong busy");

    property p_no_restart;
        busy_ff && wr_cmd |=> op_ff == $past(op_ff)
            && addr_ff == $past(addr_ff) && go_ff == $past(load_next);
    endproperty
    a_no_restart: assert property (p_no_restart)
        else $error("start accepted while busy");

    property p_write_frame;
        go_ff && eff_op == OP_WRITE |-> tx_bits == `MW_FULL_BITS && tx_wait;
    endproperty
    a_write_frame: assert property (p_write_frame)
        else $error("write frame encoded wrongly");

endmodule // eeprom_command_control

/* File: tb/eeprom_model.sv */
`timescale 1ns/1ps
// ==========================================
// Serial EEPROM behind the link, seen on the system clock
module eeprom_model (
    input wire logic clk,
    input wire logic cs,
    input wire logic sk,
    input wire logic din,
    input wire logic present,
    input wire logic [7:0] prog_cyc,
    output logic dout
);
    logic [7:0] mem [256];
    logic [18:0] sh = '0;
    logic [1:0] op = 2'h0;
    logic [7:0] a = 8'h00;
    logic [7:0] wd;
    logic sk_q = 1'b0;
    logic cs_q = 1'b0;
    logic wen = 1'b0;
    logic pend = 1'b0;
    logic rbit = 1'b0;
    int nbits = 0;
    int cnt = 0;
    initial begin
        for (int i = 0; i < 256; i++) begin
            mem[i] = 8'(i) ^ 8'h3C;
        end
        mem[0] = 8'hA5;
        dout = 1'b0;
    end
    always @(posedge clk) begin
        if (cs && sk && !sk_q) begin
            sh = {sh[17:0], din};
            nbits++;
            if (nbits == 11) begin
                op = sh[9:8];
                a = sh[7:0];
            end
            if (op == 2'h2 && nbits >= 12 && nbits <= 19) begin
                rbit = mem[a][19 - nbits];
            end
        end
        if (!cs && cs_q) begin
            pend = 1'b0;
            if (op == 2'h0 && nbits == 11) begin
                wen = (a[7:6] == 2'h3) ? 1'b1 : (a[7:6] == 2'h0) ? 1'b0 : wen;
                pend = (a[7:6] == 2'h2);
            end
            if (op == 2'h0 && nbits == 19 && a[7:6] == 2'h1) begin
                pend = 1'b1;
            end
            if ((op == 2'h1 && nbits == 19)
                || (op == 2'h3 && nbits == 11)) begin
                pend = 1'b1;
            end
            wd = (nbits == 19) ? sh[7:0] : 8'hFF;
            for (int i = 0; i < 256; i++) begin
                if (pend && wen && (op == 2'h0 || a == 8'(i))) begin
                    mem[i] = wd;
                end
            end
            // Locked part answers ready at once, as it programs nothing
            cnt = wen ? int'(prog_cyc) : 0;
            nbits = 0;
        end
        if (cs && cnt > 0) begin
            cnt--;
        end
        sk_q = sk;
        cs_q = cs;
        // Data line pulled low: deselected or absent part reads zero
        dout <= present && cs
            && ((op == 2'h2 && nbits >= 12) ? rbit : (pend && cnt == 0));
    end
endmodule // eeprom_model

/* File: tb/testbench.sv */
`timescale 1ns/1ps
module testbench
    import eeprom_pkg::*;
;
    logic CLOCK, RST, WR, RD, IRQ, EE_CS, EE_CLK, EE_DO, EE_DI, MAC_VALID;
    logic [7:0] ADDR;
    logic [31:0] WDATA, RDATA;
    logic [47:0] MAC_ADDR;
    logic present;
    logic [7:0] prog_cyc;
    int failures = 0;
    int check_count = 0;
    int cycles = 0;

    eeprom_command_control #(.TIMEOUT_CYC(200), .HALF_CYC(8),
        .SIGNATURE(8'hA5)) i_dut (.CLOCK(CLOCK), .RST(RST), .ADDR(ADDR),
        .WDATA(WDATA), .WR(WR), .RD(RD), .RDATA(RDATA), .IRQ(IRQ),
        .EE_CS(EE_CS), .EE_CLK(EE_CLK), .EE_DO(EE_DO), .EE_DI(EE_DI),
        .MAC_ADDR(MAC_ADDR), .MAC_VALID(MAC_VALID));
    eeprom_model i_mem (.clk(CLOCK), .cs(EE_CS), .sk(EE_CLK), .din(EE_DO),
        .present(present), .prog_cyc(prog_cyc), .dout(EE_DI));

    // ========
    // Bus and compare helpers
    task automatic chk(input string nm, input logic [47:0] seen,
        input logic [47:0] exp);
        check_count++;
        if (seen !== exp) begin
            failures++;
            $display("wrong value %s expected %h seen %h", nm, exp, seen);
        end
    endtask
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        ADDR <= a;
        WDATA <= d;
        WR <= 1'b1;
        @(posedge CLOCK);
        WR <= 1'b0;
        @(posedge CLOCK);
    endtask
    task automatic rd(input logic [7:0] a, output logic [31:0] d);
        ADDR <= a;
        RD <= 1'b1;
        @(posedge CLOCK);
        RD <= 1'b0;
        #1;
        d = RDATA;
        @(posedge CLOCK);
    endtask
    task automatic wait_idle(input int lim);
        logic [31:0] v;
        int k;
        v = 32'hFFFF_FFFF;
        k = 0;
        while (v[31] !== 1'b0 && k < lim) begin
            rd(8'hB0, v);
            k++;
        end
        chk("busy clear", 48'(v[31]), 48'h0);
    endtask
    task automatic cmd(input op_t op, input logic [7:0] a);
        wr(8'hB0, {1'b1, op, 20'h0_0000, a});
        wait_idle(2000);
    endtask
    task automatic getb(input logic [7:0] a, input logic [7:0] e,
        input string nm);
        logic [31:0] v;
        cmd(OP_READ, a);
        rd(8'hB4, v);
        chk(nm, 48'(v), 48'(e));
    endtask
    task automatic irq_is(input logic e, input string nm);
        @(posedge CLOCK);
        #1;
        chk(nm, 48'(IRQ), 48'(e));
    endtask
    function automatic logic [47:0] mac_exp();
        logic [47:0] m;
        for (int i = 6; i >= 1; i--) begin
            m = {m[39:0], 8'(i) ^ 8'h3C};
        end
        return m;
    endfunction

    // ========
    // Scenarios
    task automatic t_boot;
        logic [31:0] v;
        rd(8'hB0, v);
        chk("busy after reset", 48'(v[31]), 48'h1);
        chk("op after reset", 48'(v[30:28]), 48'h0);
        wait_idle(2000);
        chk("station address", MAC_ADDR, mac_exp());
        chk("address valid", 48'(MAC_VALID), 48'h1);
        rd(8'hB8, v);
        chk("load done", 48'(v[2]), 48'h1);
        $display("test boot done");
    endtask
    task automatic t_read;
        logic [31:0] v;
        wr(8'hB0, 32'h8000_0012);
        // Zero and a second start while busy must both be without effect
        wr(8'hB0, 32'h0000_0000);
        wr(8'hB0, 32'h8000_0034);
        rd(8'hB0, v);
        chk("busy held", 48'(v[31]), 48'h1);
        wait_idle(2000);
        rd(8'hB4, v);
        chk("read byte", 48'(v), 48'(8'h12 ^ 8'h3C));
        repeat (400) @(posedge CLOCK);
        rd(8'hB0, v);
        chk("no restart", 48'(v[31]), 48'h0);
        rd(8'hB4, v);
        chk("no queued read", 48'(v), 48'(8'h12 ^ 8'h3C));
        $display("test read done");
    endtask
    task automatic t_ops;
        logic [31:0] v;
        cmd(OP_EWEN, 8'h00);
        wr(8'hB4, 32'h0000_005A);
        prog_cyc <= 8'h02;
        cmd(OP_WRITE, 8'h20);
        getb(8'h20, 8'h5A, "written byte");
        prog_cyc <= 8'h64;
        cmd(OP_ERASE, 8'h20);
        rd(8'hB0, v);
        chk("command layout", 48'(v), 48'h5000_0020);
        getb(8'h20, 8'hFF, "erased byte");
        cmd(OP_EWDS, 8'h00);
        wr(8'hB4, 32'h0000_0077);
        cmd(OP_WRITE, 8'h20);
        getb(8'h20, 8'hFF, "locked byte");
        cmd(OP_RELOAD, 8'h00);
        chk("reloaded address", MAC_ADDR, mac_exp());
        chk("reload valid", 48'(MAC_VALID), 48'h1);
        cmd(OP_EWEN, 8'h00);
        wr(8'hB4, 32'h0000_00C3);
        cmd(OP_WRAL, 8'h00);
        getb(8'h55, 8'hC3, "write all");
        cmd(OP_ERAL, 8'h00);
        getb(8'h55, 8'hFF, "erase all");
        $display("test ops done");
    endtask
    task automatic t_tmo;
        logic [31:0] v;
        wr(8'hC0, 32'h0000_0007);
        present <= 1'b0;
        wr(8'hB0, {1'b1, OP_WRITE, 28'h000_0021});
        repeat (450) @(posedge CLOCK);
        rd(8'hB0, v);
        chk("busy while absent", 48'(v[31]), 48'h1);
        wait_idle(300);
        rd(8'hB8, v);
        chk("timeout status", 48'(v[1:0]), 48'h3);
        present <= 1'b1;
        $display("test timeout done");
    endtask
    task automatic t_irq;
        logic [31:0] v;
        wr(8'hC0, 32'h0000_0007);
        wr(8'hBC, 32'h0000_0001);
        irq_is(1'b0, "irq idle");
        cmd(OP_READ, 8'h01);
        irq_is(1'b1, "irq raised");
        wr(8'hC0, 32'h0000_0001);
        irq_is(1'b0, "irq cleared");
        wr(8'hBC, 32'h0000_0000);
        cmd(OP_READ, 8'h02);
        irq_is(1'b0, "irq masked");
        rd(8'hB8, v);
        chk("status sticky", 48'(v[0]), 48'h1);
        rd(8'hC0, v);
        chk("clear reads zero", 48'(v), 48'h0);
        rd(8'h40, v);
        chk("unmapped read", 48'(v), 48'h0);
        $display("test irq done");
    endtask
    task automatic t_rst;
        logic [31:0] v;
        // Array is erased by now, so this load fails yet must still end
        RST <= 1'b1;
        repeat (3) @(posedge CLOCK);
        RST <= 1'b0;
        @(posedge CLOCK);
        rd(8'hB0, v);
        chk("busy after second reset", 48'(v[31]), 48'h1);
        wait_idle(500);
        chk("failed load valid", 48'(MAC_VALID), 48'h0);
        chk("failed load address", MAC_ADDR, 48'h0);
        $display("test reset done");
    endtask

    // ========
    // Run control
    task automatic close_out;
        $display("checks %0d mismatches %0d", check_count, failures);
        if (failures == 0 && check_count > 0) begin
            $display("Finished cleanly");
        end else begin
            $display("Finished with errors");
        end
        $finish;
    endtask
    initial begin
        CLOCK = 1'b0;
        forever #12.5 CLOCK = ~CLOCK;
    end
    initial begin
        while (cycles < 40000) begin
            @(posedge CLOCK);
            cycles++;
        end
        failures++;
        $display("run timed out");
        close_out();
    end
    initial begin
        RST = 1'b1;
        ADDR = 8'h00;
        WDATA = 32'h0000_0000;
        WR = 1'b0;
        RD = 1'b0;
        present = 1'b1;
        prog_cyc = 8'h10;
        repeat (20) @(posedge CLOCK);
        RST <= 1'b0;
        @(posedge CLOCK);
        t_boot();
        t_read();
        t_ops();
        t_tmo();
        t_irq();
        t_rst();
        close_out();
    end
endmodule // testbench
